//--- logic/sleep_wake_seq.sv
// Sleep entry/exit and restart sequencer of the mesh radio core.
// Assumes pins are synchronous; tx_ready_i accepts one byte per handshake.
// Functional notes
// - Sleep command in configuration mode puts the device to sleep.
// - Flow/sleep pin controls sleep only when sleep pin select is 1.
// - With pin sleep selected, pin driven low enters sleep.
// - Pin-entered sleep ends when the pin goes high.
// - Command-entered sleep ends only when setup pin goes high.
// - Every wake runs a full power-on reset sequence.
// - Pin pull-ups are off while asleep.
// - CTS stays high through reset until network link is made.
// - With software flow, one Xoff is sent when reset ends.
// - With software flow, first Xon only after mesh link.
// - Link indicator starts flashing after wake.
// - A restart notice is issued after wake.
// - Status report after wake only if status on link flag set.
// - Router forwards no traffic while asleep.
// - Gateway sends no beacons while asleep.
// - Xoff is 0x13, Xon is 0x11.
// - Xon repeats every second while ready to receive.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_seq (
  // Clock, reset, enable.
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Configuration and host pins.
  input wire sleep_wake_pkg::cfg_t cfg_i,
  input wire logic config_mode_i,
  input wire logic sleep_cmd_i,
  input wire logic flow_or_sleep_pin_i,
  input wire logic setup_mode_pin_i,
  input wire logic net_connected_i,
  input wire logic rx_ready_i,
  // Serial transmit handshake.
  input wire logic tx_ready_i,
  output sleep_wake_pkg::tx_req_t tx_req_o,
  // Status and controls.
  output logic cts_o,
  output logic pullup_en_o,
  output logic asleep_o,
  output logic core_reset_o,
  output logic forward_en_o,
  output logic beacon_en_o,
  output logic host_rx_permit_o,
  output logic link_indicator_output_o,
  output logic status_report_o
);
  import sleep_wake_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sync_reg <= SYNC_RESET;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  seq_state_t state_reg, state_next;
  sleep_src_t src_reg;
  logic por_done, blink_tick, xon_tick;
  logic tx_valid_reg, linked_reg, xon_sent_reg, blink_reg;
  logic [7:0] tx_data_reg;
  wire tx_free = !tx_valid_reg || tx_ready_i;
  wire pin_sleep = cfg_i.sleep_pin_select;
  wire cmd_enter = config_mode_i && sleep_cmd_i;
  wire pin_enter = pin_sleep && !flow_or_sleep_pin_i;
  // Wake source must match the entry source.
  wire wake = (src_reg == SRC_PIN) ? flow_or_sleep_pin_i : setup_mode_pin_i;
  wire link_up = (state_reg == ST_RUN) && net_connected_i;
  wire xon_due = cfg_i.sw_flow_en && linked_reg && rx_ready_i && (!xon_sent_reg || xon_tick);

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  por_timer #(.COUNT(POR_HOLD_CYC)) u_por (
    .clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce_i),
    .load_i(state_reg == ST_SLEEP && wake), .done_o(por_done)
  );
  logic [31:0] blink_cnt_reg, xon_cnt_reg;
  assign blink_tick = (blink_cnt_reg == 32'h0000_0000);
  assign xon_tick = (xon_cnt_reg == 32'h0000_0000);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: if (cmd_enter || pin_enter) state_next = ST_SLEEP;
      ST_SLEEP: if (wake) state_next = ST_POR;
      ST_POR: if (por_done) state_next = cfg_i.sw_flow_en ? ST_XOFF : ST_NOTE;
      ST_XOFF: if (tx_free) state_next = ST_NOTE;
      ST_NOTE: if (tx_free) state_next = cfg_i.status_on_link_flag ? ST_STAT : ST_RUN;
      ST_STAT: if (tx_free) state_next = ST_RUN;
      default: state_next = ST_POR;
    endcase
  end

  // State register and sleep source capture.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_POR;
      src_reg <= SRC_CMD;
    end else if (ce_i) begin
      state_reg <= state_next;
      if (state_reg == ST_RUN && pin_enter) src_reg <= SRC_PIN;
      else if (state_reg == ST_RUN && cmd_enter) src_reg <= SRC_CMD;
    end
  end

  // Link tracking: cleared on each wake so Xon waits for a fresh link.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      linked_reg <= 1'b0;
      xon_sent_reg <= 1'b0;
      xon_cnt_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      linked_reg <= link_up;
      if (state_reg != ST_RUN) xon_sent_reg <= 1'b0;
      else if (xon_due && tx_free) xon_sent_reg <= 1'b1;
      if (xon_due && tx_free) xon_cnt_reg <= XON_PERIOD_CYC - 1;
      else if (!xon_tick) xon_cnt_reg <= xon_cnt_reg - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Serial byte request; a byte stays valid until the transmitter takes it.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else if (ce_i && tx_free) begin
      tx_valid_reg <= 1'b1;
      if (state_reg == ST_XOFF) tx_data_reg <= XOFF_CHAR;
      else if (state_reg == ST_NOTE) tx_data_reg <= RESTART_NOTICE_CODE;
      else if (state_reg == ST_STAT) tx_data_reg <= STATUS_REPORT_CODE;
      else if (xon_due) tx_data_reg <= XON_CHAR;
      else tx_valid_reg <= 1'b0;
    end
  end
  assign tx_req_o = '{valid: tx_valid_reg, data: tx_data_reg};

  // ----------------------------------------------------------------------
  // Indicator blink, active from the end of the power-on reset until sleep.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_reg == ST_SLEEP || state_reg == ST_POR) begin
        blink_cnt_reg <= 32'h0000_0000;
        blink_reg <= 1'b0;
      end else if (blink_tick) begin
        blink_cnt_reg <= BLINK_HALF_CYC - 1;
        blink_reg <= !blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs. CTS high rejects host bytes until linked.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cts_o <= 1'b1;
      pullup_en_o <= 1'b1;
      asleep_o <= 1'b0;
      core_reset_o <= 1'b1;
      forward_en_o <= 1'b0;
      beacon_en_o <= 1'b0;
      host_rx_permit_o <= 1'b0;
      link_indicator_output_o <= 1'b0;
      status_report_o <= 1'b0;
    end else if (ce_i) begin
      cts_o <= !(link_up && rx_ready_i);
      pullup_en_o <= (state_next != ST_SLEEP);
      asleep_o <= (state_next == ST_SLEEP);
      core_reset_o <= (state_next == ST_POR);
      forward_en_o <= cfg_i.router_role && (state_next == ST_RUN);
      beacon_en_o <= cfg_i.gateway_role && (state_next == ST_RUN);
      host_rx_permit_o <= !pin_sleep && !flow_or_sleep_pin_i;
      link_indicator_output_o <= blink_reg;
      status_report_o <= (state_reg == ST_STAT) && tx_free;
    end
  end
endmodule
`default_nettype wire

//--- inc/sleep_wake_pkg.sv
// Package for the sleep/wake sequencer: states, flow-control codes, timing.
// Assumes a 125 MHz clock and byte-wide serial transmit handshake outside.
package sleep_wake_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned XON_PERIOD_S = 1;
  localparam int unsigned XON_PERIOD_CYC = XON_PERIOD_S * CLK_HZ;
  localparam int unsigned POR_HOLD_CYC = 16;
  localparam int unsigned BLINK_HALF_CYC = 62_500_000;

  // ----------------------------------------------------------------------
  // Serial codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] RESTART_NOTICE_CODE = 8'h01;
  localparam logic [7:0] STATUS_REPORT_CODE = 8'h02;
  localparam logic [1:0] SYNC_RESET = 2'b00;

  // Main sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_RUN   = 6'b00_0001,
    ST_SLEEP = 6'b00_0010,
    ST_POR   = 6'b00_0100,
    ST_XOFF  = 6'b00_1000,
    ST_NOTE  = 6'b01_0000,
    ST_STAT  = 6'b10_0000
  } seq_state_t;

  // Byte request towards the serial transmitter.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tx_req_t;

  // Configuration inputs.
  typedef struct packed {
    logic sleep_pin_select;
    logic sw_flow_en;
    logic status_on_link_flag;
    logic router_role;
    logic gateway_role;
  } cfg_t;

  // Which source put the device to sleep.
  typedef enum logic [1:0] {
    SRC_CMD = 2'b01,
    SRC_PIN = 2'b10
  } sleep_src_t;

endpackage

//--- logic/por_timer.sv
// Down-counter used for the power-on hold; the blink and Xon timers are counted in the sequencer.
// Assumes an asynchronous active-low reset and a shared clock enable.
`timescale 1ns/1ps
`default_nettype none
module por_timer #(
  parameter int unsigned COUNT = 16
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Control.
  input wire logic load_i,
  output logic done_o
);
  logic [31:0] cnt_reg;

  // Reload on request, otherwise count down and flag zero from a register.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= COUNT - 1; // A reset starts a full hold, so the block's own reset runs the power-on sequence.
      done_o <= 1'b0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_reg <= COUNT - 1;
        done_o <= 1'b0;
      end else if (cnt_reg != 32'h0000_0000) begin
        cnt_reg <= cnt_reg - 32'h0000_0001;
        done_o <= (cnt_reg == 32'h0000_0001);
      end else begin
        done_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/sleep_wake_seq_assertions.sv
// Checker for the sleep/wake sequencer.
// Assumes it is bound to sleep_wake_seq and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_seq_assertions (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Inputs.
  input wire sleep_wake_pkg::cfg_t cfg_i,
  input wire logic config_mode_i,
  input wire logic sleep_cmd_i,
  input wire logic flow_or_sleep_pin_i,
  input wire logic setup_mode_pin_i,
  input wire logic net_connected_i,
  // Outputs.
  input wire sleep_wake_pkg::tx_req_t tx_req_o,
  input wire logic cts_o,
  input wire logic pullup_en_o,
  input wire logic asleep_o,
  input wire logic core_reset_o,
  input wire logic forward_en_o,
  input wire logic beacon_en_o,
  input wire logic host_rx_permit_o,
  input wire logic status_report_o,
  input wire logic link_indicator_output_o
);
  import sleep_wake_pkg::*;
  // One domain, so clock and reset are given once.
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_sleep_has_cause: assert property (
    $rose(asleep_o) |-> $past(config_mode_i && sleep_cmd_i || cfg_i.sleep_pin_select && !flow_or_sleep_pin_i))
    else $error("sleep entered without a cause");
  a_stay_asleep: assert property (
    asleep_o && !flow_or_sleep_pin_i && !setup_mode_pin_i |=> asleep_o) else $error("woke with no wake pin high");
  a_sleep_pullups: assert property (asleep_o |-> !pullup_en_o) else $error("pull-ups on in sleep");
  a_no_forward: assert property (asleep_o |-> !forward_en_o) else $error("forwarding in sleep");
  a_no_beacon: assert property (asleep_o |-> !beacon_en_o) else $error("beacons in sleep");
  a_wake_por: assert property ($fell(asleep_o) |-> core_reset_o) else $error("wake without reset");
  a_cts_held: assert property (
    core_reset_o || !$past(net_connected_i) |-> cts_o) else $error("cts low before link");
  a_permit_masked: assert property (
    cfg_i.sleep_pin_select && $past(cfg_i.sleep_pin_select) |-> !host_rx_permit_o) else $error("pin read as permit");
  a_xon_link: assert property (
    tx_req_o.valid && tx_req_o.data == XON_CHAR |-> $past(net_connected_i)) else $error("xon before link");
  a_status_flag: assert property (
    status_report_o |-> cfg_i.status_on_link_flag) else $error("status report with flag off");
  a_blink_start: assert property (
    $fell(core_reset_o) |-> ##2 link_indicator_output_o) else $error("indicator idle after wake");
endmodule
bind sleep_wake_seq sleep_wake_seq_assertions u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_i(cfg_i),
  .config_mode_i(config_mode_i), .sleep_cmd_i(sleep_cmd_i), .flow_or_sleep_pin_i(flow_or_sleep_pin_i),
  .setup_mode_pin_i(setup_mode_pin_i), .net_connected_i(net_connected_i), .tx_req_o(tx_req_o), .cts_o(cts_o),
  .pullup_en_o(pullup_en_o), .asleep_o(asleep_o), .core_reset_o(core_reset_o), .forward_en_o(forward_en_o),
  .beacon_en_o(beacon_en_o), .host_rx_permit_o(host_rx_permit_o), .status_report_o(status_report_o),
  .link_indicator_output_o(link_indicator_output_o));
`default_nettype wire

//--- test/host_serial_sink.sv
// Host-side model that takes bytes from the sequencer's transmit request.
// Assumes the bench picks prompt or stalling acceptance.
`timescale 1ns/1ps
`default_nettype none
module host_serial_sink (
  // Clock and byte request.
  input wire logic clk_i,
  input wire sleep_wake_pkg::tx_req_t tx_req_i,
  input wire logic slow_i,
  output logic tx_ready_o
);
  logic [1:0] stall_reg = 2'h0;
  // Slow mode accepts one edge in four, so the request must hold across stalls.
  always @(posedge clk_i) begin
    stall_reg <= stall_reg + 2'h1;
    tx_ready_o <= !slow_i || stall_reg == 2'h3;
  end
endmodule
`default_nettype wire

//--- test/sleep_wake_seq_tb.sv
// Self-checking bench for the sleep/wake sequencer.
// Assumes package, design, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_seq_tb;
  import sleep_wake_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, cmode = 1'b0, cmd = 1'b0, fpin = 1'b1, spin = 1'b0, link = 1'b0;
  logic ce = 1'b1, rxr = 1'b0, slow = 1'b0, txr, cts, pup, asleep, creset, fwd, bcn, permit, blink, stat;
  cfg_t cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  tx_req_t txq;
  logic [7:0] expq[$];
  int err_count = 0;
  int check_count = 0;
  integer seed = 32'h875f_9356;
  always #4 clk = ~clk;
  sleep_wake_seq dut (.clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .cfg_i(cfg), .config_mode_i(cmode),
    .sleep_cmd_i(cmd), .flow_or_sleep_pin_i(fpin), .setup_mode_pin_i(spin), .net_connected_i(link),
    .rx_ready_i(rxr), .tx_ready_i(txr), .tx_req_o(txq), .cts_o(cts), .pullup_en_o(pup), .asleep_o(asleep),
    .core_reset_o(creset), .forward_en_o(fwd), .beacon_en_o(bcn), .host_rx_permit_o(permit),
    .link_indicator_output_o(blink), .status_report_o(stat));
  host_serial_sink host (.clk_i(clk), .tx_req_i(txq), .slow_i(slow), .tx_ready_o(txr));
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait, so a stuck sequencer cannot hang the run.
  task automatic drain();
    for (int i = 0; i < 400 && expq.size() != 0; i++) @(negedge clk);
    chk("bytes left", 8'h00, 8'(expq.size()));
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Each accepted byte is matched to the oldest note; an unnoted byte meets an unknown.
  always @(posedge clk) begin
    if (txq.valid === 1'b1 && txr === 1'b1) chk("tx byte", expq.size() ? expq.pop_front() : 8'hxx, txq.data);
  end
  initial begin
    {cfg.router_role, cfg.gateway_role} = 2'($random(seed));
    expq = '{XOFF_CHAR, RESTART_NOTICE_CODE, STATUS_REPORT_CODE};
    cyc(10);
    arst_n = 1'b1;
    drain();
    chk("cts no link", 8'h01, {7'h00, cts});
    chk("link indicator", 8'h01, {7'h00, blink});
    chk("fwd beacon run", {6'h00, cfg.router_role, cfg.gateway_role}, {6'h00, fwd, bcn});
    expq.push_back(XON_CHAR);
    link = 1'b1;
    rxr = 1'b1;
    drain();
    cyc(2);
    chk("cts linked", 8'h00, {7'h00, cts});
    // Pin sleep with a stalling host; the setup pin must not wake it.
    slow = 1'b1;
    fpin = 1'b0;
    spin = 1'b1;
    cyc(3);
    chk("pin sleep", 8'h01, {7'h00, asleep});
    chk("pullups", 8'h00, {7'h00, pup});
    chk("fwd beacon", 8'h00, {6'h00, fwd, bcn});
    // A low clock enable must freeze the sequencer even with the wake level on the pin.
    ce = 1'b0;
    fpin = 1'b1;
    cyc(3);
    chk("frozen", 8'h03, {6'h00, asleep, !creset});
    // Both pins low while asleep must keep the device asleep.
    ce = 1'b1;
    fpin = 1'b0;
    spin = 1'b0;
    cyc(2);
    chk("still asleep", 8'h01, {7'h00, asleep});
    expq = '{XOFF_CHAR, RESTART_NOTICE_CODE, STATUS_REPORT_CODE, XON_CHAR};
    fpin = 1'b1;
    cyc(2);
    chk("wake reset", 8'h01, {7'h00, creset});
    drain();
    // Command sleep with the pin as plain permit input.
    cfg.sleep_pin_select = 1'b0;
    cfg.sw_flow_en = 1'b0;
    cfg.status_on_link_flag = 1'b0;
    fpin = 1'b0;
    cyc(3);
    chk("permit", 8'h02, {6'h00, permit, asleep});
    fpin = 1'b1;
    cmode = 1'b1;
    cmd = 1'b1;
    cyc(1);
    cmd = 1'b0;
    cyc(4);
    chk("cmd sleep", 8'h01, {7'h00, asleep});
    cmode = 1'b0;
    expq = '{RESTART_NOTICE_CODE};
    spin = 1'b1;
    cyc(2);
    chk("cmd wake", 8'h01, {7'h00, creset});
    drain();
    cyc(30);
    final_report();
  end
  initial begin
    #100_000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
